//--- design/embedded_power_controller.sv
// Top of the embedded power controller: arbitration and power state machine.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.svh"
module embedded_power_controller
    import power_ctl_pkg::*;
#(
    parameter int NUM_RES = 8,
    parameter int STEPS = 8,
    parameter int ALWAYS_ON_RES = 0
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_above_por,
    input wire logic i_above_sys_low,
    input wire logic i_above_sys_high,
    input wire logic i_hot_die,
    input wire logic i_on_req,
    input wire logic i_off_req,
    input wire logic i_wake_req,
    input wire logic i_sleep_req,
    input wire logic i_check_en,
    input wire logic i_check_ok,
    input wire logic i_check_stop,
    input wire logic [5*STEPS*(NUM_RES+2)-1:0] i_seq_rom,
    input wire logic [NUM_RES*2-1:0] i_default_mode,
    input wire logic [NUM_RES*2-1:0] i_sleep_mode,
    input wire logic [NUM_RES*NUM_RES-1:0] i_link_map,
    input wire logic i_host_wr,
    input wire logic [7:0] i_host_res,
    input wire logic [1:0] i_host_mode,
    output logic [NUM_RES-1:0] o_res_en,
    output logic [NUM_RES-1:0] o_res_low_power,
    output logic [4:0] o_power_state,
    output logic o_seq_busy,
    output logic o_seq_done,
    output logic o_check_err
);
    localparam int TICK_DIV = `REF_CLK_HZ / `SLOW_OSC_HZ;
    localparam int TW = $clog2(TICK_DIV + 1);
    initial begin
        if (ALWAYS_ON_RES >= NUM_RES || NUM_RES > 256 || TICK_DIV < 1) begin
            $error("embedded_power_controller: bad parameters");
        end
    end
    function automatic logic [1:0] mode_of(input logic [NUM_RES*2-1:0] v, input int i);
        mode_of = v[i*2 +: 2];
    endfunction : mode_of
    power_state_type state_ff;
    power_state_type nxt_state;
    power_state_type target_ff;
    logic [TW-1:0] tick_cnt_ff;
    logic tick_ff;
    logic start_ff;
    logic [`SEQ_ID_W-1:0] seq_id_ff;
    logic [NUM_RES*2-1:0] host_mode_ff;
    logic [NUM_RES-1:0] en_ff;
    logic [NUM_RES-1:0] lp_ff;
    logic [4:0] state_out_ff;
    logic done_q_ff;
    logic err_q_ff;
    logic busy_q_ff;
    logic [NUM_RES*2-1:0] seq_mode;
    logic seq_done;
    logic seq_busy;
    logic seq_err;
    // Slow oscillator tick derived from the reference clock.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (i_ce) begin
            tick_ff <= (32'(tick_cnt_ff) == TICK_DIV - 1);
            tick_cnt_ff <= (32'(tick_cnt_ff) == TICK_DIV - 1) ? '0 : tick_cnt_ff + 1'b1;
        end
    end
    // Arbitration: off beats sleep beats wake beats on.
    wire want_off = i_off_req && (state_ff == ST_ACTIVE || state_ff == ST_SLEEP);
    wire want_sleep = i_sleep_req && state_ff == ST_ACTIVE && !want_off;
    wire want_wake = i_wake_req && state_ff == ST_SLEEP && !want_off;
    wire gate_on = !i_above_sys_high || i_hot_die;
    wire want_on = i_on_req && state_ff == ST_OFF && !gate_on;
    wire req_ok = !seq_busy && !start_ff && i_above_sys_low;
    wire do_seq = req_ok && (want_off || want_sleep || want_wake || want_on);
    wire [`SEQ_ID_W-1:0] pick_id = want_off ? ((state_ff == ST_SLEEP) ? `SEQ_SLP_TO_OFF
        : `SEQ_ACT_TO_OFF) : want_sleep ? `SEQ_ACT_TO_SLP : want_wake ? `SEQ_SLP_TO_ACT
        : want_on ? `SEQ_OFF_TO_ACT : `SEQ_NONE;
    wire power_lost = !i_above_por;
    wire check_blocked = seq_err && i_check_stop;
    // Power-up starts from stored defaults; other sequences keep the live control bits.
    wire [NUM_RES*2-1:0] seq_base_mode = (seq_id_ff == `SEQ_OFF_TO_ACT)
        ? i_default_mode : host_mode_ff;
    // Power state next value.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_NO_SUPPLY: nxt_state = ST_BACKUP;
            ST_BACKUP: if (i_above_sys_low) nxt_state = ST_OFF;
            ST_OFF, ST_ACTIVE, ST_SLEEP: begin
                if (!i_above_sys_low) begin
                    nxt_state = ST_BACKUP;
                end else if (seq_done && !check_blocked) begin
                    nxt_state = target_ff;
                end
            end
            default: nxt_state = ST_NO_SUPPLY;
        endcase
        if (power_lost) begin
            nxt_state = ST_NO_SUPPLY;
        end
    end
    // Power state, request latch and target.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_ff <= ST_NO_SUPPLY;
            target_ff <= ST_OFF;
            start_ff <= 1'b0;
            seq_id_ff <= `SEQ_NONE;
        end else if (i_ce) begin
            state_ff <= nxt_state;
            start_ff <= do_seq && !power_lost;
            if (do_seq) begin
                seq_id_ff <= pick_id;
                target_ff <= (want_off) ? ST_OFF : (want_sleep) ? ST_SLEEP : ST_ACTIVE;
            end
        end
    end
    power_sequencer #(
        .NUM_RES(NUM_RES),
        .STEPS(STEPS)
    ) u_seq (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_abort(power_lost || !i_above_sys_low),
        .i_tick(tick_ff),
        .i_start(start_ff),
        .i_seq_id(seq_id_ff),
        .i_check_en(i_check_en),
        .i_check_ok(i_check_ok),
        .i_check_stop(i_check_stop),
        .i_seq_rom(i_seq_rom),
        .i_default_mode(seq_base_mode),
        .o_res_mode(seq_mode),
        .o_done(seq_done),
        .o_busy(seq_busy),
        .o_check_err(seq_err)
    );
    // Host writes land in the same control bits the sequencer writes.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            host_mode_ff <= '0;
        end else if (i_ce) begin
            if (start_ff) begin
                // Host writes are ignored; power-up drops to defaults before resources switch.
                if (seq_id_ff == `SEQ_OFF_TO_ACT) begin
                    host_mode_ff <= i_default_mode;
                end
            end else if (seq_busy) begin
                host_mode_ff <= seq_mode;
            end else if (i_host_wr && 32'(i_host_res) < NUM_RES) begin
                host_mode_ff[32'(i_host_res)*2 +: 2] <= i_host_mode;
            end else if (seq_done) begin
                host_mode_ff <= seq_mode;
            end
        end
    end
    // Per-resource enable and low-power decode.
    logic [NUM_RES-1:0] res_on;
    logic [NUM_RES-1:0] res_lp;
    genvar g;
    generate
        for (g = 0; g < NUM_RES; g++) begin : g_res
            wire [1:0] base = mode_of(host_mode_ff, g);
            wire [1:0] slp = mode_of(i_sleep_mode, g);
            wire [1:0] eff = (state_ff == ST_SLEEP && base != `RES_MODE_OFF) ? slp : base;
            wire own_on = (g == ALWAYS_ON_RES) ? (state_ff != ST_NO_SUPPLY)
                : ((state_ff == ST_ACTIVE || state_ff == ST_SLEEP || seq_busy)
                && eff != `RES_MODE_OFF);
            assign res_lp[g] = own_on && eff == `RES_MODE_SLEEP;
            logic linked;
            always_comb begin
                linked = 1'b0;
                for (int k = 0; k < NUM_RES; k++) begin
                    if (i_link_map[k*NUM_RES + g] && state_ff == ST_SLEEP
                        && mode_of(i_sleep_mode, k) == `RES_MODE_ON
                        && mode_of(host_mode_ff, k) != `RES_MODE_OFF) begin
                        linked = 1'b1;
                    end
                end
            end
            assign res_on[g] = own_on || linked;
        end
    endgenerate
    // Registered outputs.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            en_ff <= '0;
            lp_ff <= '0;
            state_out_ff <= 5'h01;
            done_q_ff <= 1'b0;
            err_q_ff <= 1'b0;
            busy_q_ff <= 1'b0;
        end else if (i_ce) begin
            en_ff <= res_on;
            lp_ff <= res_lp;
            state_out_ff <= state_ff;
            done_q_ff <= seq_done;
            err_q_ff <= seq_err;
            busy_q_ff <= seq_busy;
        end
    end
    assign o_res_en = en_ff;
    assign o_res_low_power = lp_ff;
    assign o_power_state = state_out_ff;
    assign o_seq_busy = busy_q_ff;
    assign o_seq_done = done_q_ff;
    assign o_check_err = err_q_ff;
    a_no_supply_state: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && !i_above_por) |=> state_ff == ST_NO_SUPPLY)
        else $error("no-supply not entered");
    a_backup_state: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && i_above_por && !i_above_sys_low) |=> state_ff == ST_BACKUP)
        else $error("backup not entered");
    a_active_gate: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (do_seq && pick_id == `SEQ_OFF_TO_ACT) |-> i_above_sys_high)
        else $error("start-up without high supply");
    a_legal_moves: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_ff != $past(state_ff) && (state_ff == ST_ACTIVE || state_ff == ST_SLEEP))
        |-> ((state_ff == ST_ACTIVE)
        ? ($past(state_ff) == ST_OFF || $past(state_ff) == ST_SLEEP)
        : ($past(state_ff) == ST_ACTIVE)))
        else $error("illegal transition");
    a_off_only_aon: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (state_ff == ST_OFF && !seq_busy && !start_ff && i_ce && i_above_por && i_above_sys_low)
        |=> (res_on == NUM_RES'(1) << ALWAYS_ON_RES))
        else $error("resource on in off");
    a_one_winner: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        do_seq |-> $onehot({want_off, want_sleep, want_wake, want_on}))
        else $error("more than one winner");
    c_power_up: cover property (@(posedge i_ref_clk) state_ff == ST_ACTIVE);
    c_sleep: cover property (@(posedge i_ref_clk) state_ff == ST_SLEEP);
    c_check_err: cover property (@(posedge i_ref_clk) seq_err);
endmodule : embedded_power_controller
`default_nettype wire

//--- design/power_ctl_defs.svh
// Constants and rule summary for the embedded power controller.
// How it works
// - Four request kinds select one of five sequences.
// - Any resource may appear in any sequence.
// - Untouched resources keep their stored defaults (power-up only; other sequences keep the live control bits).
// - Resources change only through their control bits.
// - Transitions are ordered series of register writes.
// - Arbiter picks one winner among simultaneous requests.
// - State machine uses supply flags and request.
// - Sequencer reads stored steps and applies them.
// - Supply below reset threshold means no-supply state.
// - Between reset and low thresholds means backup.
// - Off keeps only always-on supply enabled (while a sequence runs in off, other resources follow their control bits).
// - Active needs start-up with supply above high.
// - Sleep applies each resource's own low-power setting.
// - Resource kept on keeps linked subsystems on.
// - Sequencing is timed by the slow oscillator.
// - Hardware enters off before sequences take effect.
// - Only five transitions are allowed.
// - Integrity check starts every off-to-active sequence.
`ifndef POWER_CTL_DEFS_SVH
`define POWER_CTL_DEFS_SVH
`define SLOW_OSC_HZ 32768
`define REF_CLK_HZ 100000000
`define SEQ_ID_W 3
`define SEQ_OFF_TO_ACT 3'h0
`define SEQ_ACT_TO_OFF 3'h1
`define SEQ_SLP_TO_OFF 3'h2
`define SEQ_ACT_TO_SLP 3'h3
`define SEQ_SLP_TO_ACT 3'h4
`define SEQ_NONE 3'h7
`define STEP_ADDR_W 8
`define STEP_MODE_W 2
`define RES_MODE_OFF 2'h0
`define RES_MODE_ON 2'h1
`define RES_MODE_SLEEP 2'h2
`define RES_MODE_HOLD 2'h3
`endif

//--- design/power_ctl_pkg.sv
// Types shared by the embedded power controller.
package power_ctl_pkg;
    typedef enum logic [4:0] {
        ST_NO_SUPPLY = 5'h01,
        ST_BACKUP = 5'h02,
        ST_OFF = 5'h04,
        ST_ACTIVE = 5'h08,
        ST_SLEEP = 5'h10
    } power_state_type;
    typedef enum logic [3:0] {
        SQ_IDLE = 4'h1,
        SQ_CHECK = 4'h2,
        SQ_STEP = 4'h4,
        SQ_DONE = 4'h8
    } seq_state_type;
endpackage : power_ctl_pkg

//--- design/power_sequencer.sv
// Sequencer that walks a stored sequence one step per slow tick.
`timescale 1ns/1ps
`default_nettype none
`include "power_ctl_defs.svh"
module power_sequencer
    import power_ctl_pkg::*;
#(
    parameter int NUM_RES = 8,
    parameter int STEPS = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_abort,
    input wire logic i_tick,
    input wire logic i_start,
    input wire logic [`SEQ_ID_W-1:0] i_seq_id,
    input wire logic i_check_en,
    input wire logic i_check_ok,
    input wire logic i_check_stop,
    input wire logic [5*STEPS*(NUM_RES+2)-1:0] i_seq_rom,
    input wire logic [NUM_RES*2-1:0] i_default_mode,
    output logic [NUM_RES*2-1:0] o_res_mode,
    output logic o_done,
    output logic o_busy,
    output logic o_check_err
);
    localparam int SW = NUM_RES + 2;
    localparam int IW = $clog2(STEPS + 1);
    initial begin
        if (NUM_RES < 1 || STEPS < 1 || NUM_RES > 256) begin
            $error("power_sequencer: bad parameters");
        end
    end
    seq_state_type state_ff;
    seq_state_type nxt_state;
    logic [IW-1:0] idx_ff;
    logic [`SEQ_ID_W-1:0] sel_ff;
    logic [NUM_RES*2-1:0] mode_ff;
    logic done_ff;
    logic err_ff;
    // A step word: valid bit, resource index, new mode.
    wire [SW-1:0] step_word = i_seq_rom[(32'(sel_ff) * STEPS + 32'(idx_ff)) * SW +: SW];
    wire step_valid = step_word[SW-1];
    wire [1:0] step_mode = step_word[1:0];
    wire [SW-4:0] step_res = step_word[SW-2:2];
    wire last_step = (32'(idx_ff) == STEPS - 1) || !step_valid;
    // Next-state selection.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SQ_IDLE: if (i_start) nxt_state = (i_seq_id == `SEQ_OFF_TO_ACT && i_check_en)
                ? SQ_CHECK : SQ_STEP;
            SQ_CHECK: if (!i_check_ok && i_check_stop) nxt_state = SQ_DONE;
                else nxt_state = SQ_STEP;
            SQ_STEP: if (i_tick && last_step) nxt_state = SQ_DONE;
            SQ_DONE: nxt_state = SQ_IDLE;
            default: nxt_state = SQ_IDLE;
        endcase
    end
    // State, step index and resource modes.
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_ff <= SQ_IDLE;
            idx_ff <= '0;
            sel_ff <= '0;
            mode_ff <= '0;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (i_ce) begin
            done_ff <= 1'b0;
            if (i_abort) begin
                state_ff <= SQ_IDLE;
                mode_ff <= '0;
            end else begin
                state_ff <= nxt_state;
                // Each sequence starts from the modes the parent hands in at start.
                if (state_ff == SQ_IDLE && i_start) begin
                    sel_ff <= i_seq_id;
                    idx_ff <= '0;
                    mode_ff <= i_default_mode;
                end
                if (state_ff == SQ_CHECK) begin
                    err_ff <= !i_check_ok;
                end
                if (state_ff == SQ_STEP && i_tick) begin
                    idx_ff <= idx_ff + 1'b1;
                    if (step_valid && 32'(step_res) < NUM_RES) begin
                        mode_ff[32'(step_res)*2 +: 2] <= step_mode;
                    end
                end
                if (nxt_state == SQ_DONE) begin
                    done_ff <= 1'b1;
                end
            end
        end
    end
    assign o_res_mode = mode_ff;
    assign o_done = done_ff;
    assign o_busy = (state_ff != SQ_IDLE);
    assign o_check_err = err_ff;
    a_one_step_tick: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && state_ff == SQ_STEP && !i_tick && !i_abort) |=> $stable(idx_ff))
        else $error("step advanced without tick");
    a_abort_idle: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (i_ce && i_abort) |=> state_ff == SQ_IDLE)
        else $error("abort did not stop sequence");
endmodule : power_sequencer
`default_nettype wire

//--- bench/host_model.sv
// Host processor model that makes static resource writes.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic i_ref_clk,
    output logic o_host_wr,
    output logic [7:0] o_host_res,
    output logic [1:0] o_host_mode
);
    // An idle bus shows the inverse of the last value, so stale data never passes for a write.
    initial begin
        o_host_wr = 1'b0;
        o_host_res = 8'hff;
        o_host_mode = 2'h3;
    end

    // One-cycle static write of a resource mode; the controller owns the same bits meanwhile.
    task automatic write(input logic [7:0] res, input logic [1:0] mode);
        @(posedge i_ref_clk);
        o_host_wr <= 1'b1;
        o_host_res <= res;
        o_host_mode <= mode;
        @(posedge i_ref_clk);
        o_host_wr <= 1'b0;
        o_host_res <= ~res;
        o_host_mode <= ~mode;
    endtask : write
endmodule : host_model
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the embedded power controller.
`timescale 1ns/1ps
`default_nettype none
module tb
    import power_ctl_pkg::*;
;
    logic i_ref_clk;
    logic i_reset;
    logic por, low, high, hot, ck_en, ck_ok, ck_stop;
    logic [3:0] req;
    logic [399:0] rom;
    logic [63:0] link;
    logic host_wr;
    logic [7:0] host_res;
    logic [1:0] host_mode;
    logic [7:0] res_en;
    logic [7:0] res_lp;
    logic [4:0] pstate;
    logic busy, done, cerr;
    int n_fail = 0;
    int compares = 0;

    // Device under test with the host model on its static write port.
    embedded_power_controller embedded_power_controller_i (
        .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_above_por(por), .i_above_sys_low(low), .i_above_sys_high(high),
        .i_hot_die(hot), .i_on_req(req[0]), .i_off_req(req[3]),
        .i_wake_req(req[1]), .i_sleep_req(req[2]), .i_check_en(ck_en),
        .i_check_ok(ck_ok), .i_check_stop(ck_stop), .i_seq_rom(rom),
        .i_default_mode(16'h0000), .i_sleep_mode(16'h0120), .i_link_map(link),
        .i_host_wr(host_wr), .i_host_res(host_res), .i_host_mode(host_mode),
        .o_res_en(res_en), .o_res_low_power(res_lp), .o_power_state(pstate),
        .o_seq_busy(busy), .o_seq_done(done), .o_check_err(cerr));
    host_model host_model_i (.i_ref_clk(i_ref_clk), .o_host_wr(host_wr),
        .o_host_res(host_res), .o_host_mode(host_mode));

    // Free-running 100 MHz reference clock.
    always #5 i_ref_clk = ~i_ref_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Compares one settled value against its expectation.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // A wait that ran out of cycles ends the run.
    task automatic over(input string what);
        n_fail++;
        $display("wrong value at %0t: timeout on %s", $time, what);
        tally_and_finish();
    endtask : over

    // Lets n edges pass and samples just after the last one.
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : cyc

    // Stores one valid step: seq, step, resource index, mode.
    task automatic set_step(input int s, input int t, input logic [6:0] r, input logic [1:0] m);
        rom[(s*8+t)*10 +: 10] = {1'b1, r, m};
    endtask : set_step

    // Waits for a power state under a bound.
    task automatic wait_state(input logic [4:0] exp, input int bound);
        int k;
        k = 0;
        while (pstate !== exp && k < bound) begin
            cyc(1);
            k++;
        end
        if (pstate !== exp) over("power state");
    endtask : wait_state

    // Holds a request until taken, then waits for completion and checks the new state.
    task automatic run_seq(input logic [3:0] mask, input logic [4:0] exp, output int len);
        int k;
        k = 0;
        @(posedge i_ref_clk);
        req <= mask;
        cyc(1);
        while (busy !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        if (busy !== 1'b1) over("sequence start");
        @(posedge i_ref_clk);
        req <= 4'h0;
        len = 0;
        while (done !== 1'b1 && len < 20000) begin
            cyc(1);
            len++;
        end
        if (done !== 1'b1) over("sequence done");
        cyc(4);
        chk(pstate, exp, "state after sequence");
    endtask : run_seq

    // Holds a request that must be refused and checks that nothing starts.
    task automatic refuse(input logic [3:0] mask);
        logic [4:0] was;
        logic seen;
        was = pstate;
        seen = 1'b0;
        @(posedge i_ref_clk);
        req <= mask;
        repeat (8) begin
            cyc(1);
            seen = seen | busy;
        end
        @(posedge i_ref_clk);
        req <= 4'h0;
        cyc(2);
        chk(seen, 0, "refused request started");
        chk(pstate, was, "refused request state");
    endtask : refuse

    // Supply thresholds walk the state machine up to off.
    task automatic t_supply;
        chk(pstate, ST_NO_SUPPLY, "below reset threshold");
        @(posedge i_ref_clk);
        por <= 1'b1;
        wait_state(ST_BACKUP, 10);
        chk(pstate, ST_BACKUP, "between thresholds");
        @(posedge i_ref_clk);
        low <= 1'b1;
        wait_state(ST_OFF, 10);
        chk(pstate, ST_OFF, "above low threshold");
        chk(res_en & 8'hfe, 8'h00, "resources in off");
        $display("test supply done");
    endtask : t_supply

    // Off, sleep and wake are refused in off; on is gated by supply and temperature.
    task automatic t_refuse;
        refuse(4'b1000);
        refuse(4'b0100);
        refuse(4'b0010);
        refuse(4'b0001);
        @(posedge i_ref_clk);
        high <= 1'b1;
        hot <= 1'b1;
        refuse(4'b0001);
        @(posedge i_ref_clk);
        hot <= 1'b0;
        $display("test refuse done");
    endtask : t_refuse

    // Power-on with integrity check passing; two steps need at least one slow tick.
    task automatic t_on;
        int len;
        run_seq(4'b0001, ST_ACTIVE, len);
        chk(len >= 3000, 1, "two steps inside one slow tick");
        chk(res_en & 8'hfe, 8'h0c, "resources after power-on");
        chk(cerr, 0, "check error with good memory");
        $display("test on done");
    endtask : t_on

    // Static host write reaches a resource while no sequence runs.
    task automatic t_host;
        host_model_i.write(8'h04, 2'h1);
        cyc(4);
        chk(res_en[4], 1, "host write");
        $display("test host done");
    endtask : t_host

    // Sleep applies each resource's low-power setting and keeps linked ones on.
    task automatic t_sleep;
        int len;
        run_seq(4'b0100, ST_SLEEP, len);
        chk(res_lp[2], 1, "resource in sleep mode");
        chk(res_en[4], 1, "resource kept on in sleep");
        chk(res_en[6], 1, "linked resource");
        $display("test sleep done");
    endtask : t_sleep

    // Wake while the host tries a write that the running sequence must ignore.
    task automatic t_wake;
        int len;
        fork
            run_seq(4'b0010, ST_ACTIVE, len);
            begin
                cyc(200);
                host_model_i.write(8'h01, 2'h1);
            end
        join
        chk(res_en[2], 1, "resource after wake");
        chk(res_en[1], 0, "host write during sequence");
        $display("test wake done");
    endtask : t_wake

    // Off from sleep, or from active with a competing sleep request.
    task automatic t_off(input logic [3:0] mask);
        int len;
        run_seq(mask, ST_OFF, len);
        chk(res_en & 8'hfe, 8'h00, "resources after off");
        $display("test off done");
    endtask : t_off

    // Integrity failure with stop keeps the device off.
    task automatic t_check_err;
        int k;
        k = 0;
        @(posedge i_ref_clk);
        ck_ok <= 1'b0;
        req <= 4'b0001;
        cyc(1);
        while (busy !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        if (busy !== 1'b1) over("check start");
        @(posedge i_ref_clk);
        req <= 4'h0;
        k = 0;
        while (busy !== 1'b0 && k < 20000) begin
            cyc(1);
            k++;
        end
        if (busy !== 1'b0) over("check end");
        chk(cerr, 1, "integrity error flag");
        cyc(4);
        chk(pstate, ST_OFF, "state after integrity error");
        @(posedge i_ref_clk);
        ck_ok <= 1'b1;
        $display("test check error done");
    endtask : t_check_err

    // Supply loss in mid-sequence abandons it.
    task automatic t_loss;
        @(posedge i_ref_clk);
        req <= 4'b0001;
        cyc(300);
        chk(busy, 1, "sequence running");
        @(posedge i_ref_clk);
        req <= 4'h0;
        por <= 1'b0;
        low <= 1'b0;
        high <= 1'b0;
        wait_state(ST_NO_SUPPLY, 10);
        cyc(3);
        chk(busy, 0, "sequence abandoned");
        $display("test supply loss done");
    endtask : t_loss

    // Reset, memory contents and the scenario list.
    initial begin
        i_ref_clk = 1'b0;
        i_reset = 1'b1;
        {por, low, high, hot, req} = '0;
        {ck_en, ck_ok, ck_stop} = 3'b111;
        rom = '0;
        link = 64'h0000_0040_0000_0000;
        set_step(0, 0, 7'h02, 2'h1);
        set_step(0, 1, 7'h03, 2'h1);
        set_step(1, 0, 7'h02, 2'h0);
        set_step(1, 1, 7'h03, 2'h0);
        set_step(2, 0, 7'h02, 2'h0);
        set_step(2, 1, 7'h03, 2'h0);
        set_step(3, 0, 7'h02, 2'h2);
        set_step(4, 0, 7'h02, 2'h1);
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        cyc(2);
        t_supply();
        t_refuse();
        t_on();
        t_host();
        t_sleep();
        t_wake();
        t_sleep();
        t_off(4'b1000);
        t_on();
        t_off(4'b1100);
        t_check_err();
        t_loss();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
